// ---- tb.sv ----
/* Self-checking bench for uef_regs.
   Assumes the package, FIFO, checker and host model are compiled first. */
`timescale 1ns/100ps
module tb;
  import uef_pkg::*;
  logic i_clock, i_arst_n, i_clk_en, i_sfr_wr, i_sfr_rd, o_sof_irq;
  logic i_sof_pid, i_sof_done, i_sof_crc_ok, i_rx_data_pid, i_rx_valid, i_rx_end;
  logic o_rx_ready, o_tx_valid, i_tx_ready;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_rx_byte, o_tx_byte, b;
  logic [10:0] i_sof_frame;
  logic [1:0] i_endpoint_select, i_rx_ep, i_tx_ep;
  int bad_count;
  int check_count;
  uef_regs uef_regs_i (.*);
  uef_host_model uef_host_model_i (.i_clock, .i_rx_ready(o_rx_ready),
    .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte), .o_sof_pid(i_sof_pid),
    .o_sof_done(i_sof_done), .o_sof_frame(i_sof_frame), .o_sof_ok(i_sof_crc_ok),
    .o_rx_ep(i_rx_ep), .o_rx_pid(i_rx_data_pid), .o_rx_valid(i_rx_valid),
    .o_rx_byte(i_rx_byte), .o_rx_end(i_rx_end), .o_tx_ready(i_tx_ready));
  initial begin
    i_clock = 1'h0;
    forever #50 i_clock = ~i_clock;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'h1;
    @(posedge i_clock);
    i_sfr_wr <= 1'h0;
  endtask
  task rd8(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'h1;
    @(posedge i_clock);
    i_sfr_rd <= 1'h0;
    #1 chk(o_sfr_rdata, e);
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_reset;
    rd8(UEF_ADDR_FRAME_LOW, 8'h00);
    rd8(UEF_ADDR_FRAME_HIGH, 8'h00);
    rd8(UEF_ADDR_BYTE_COUNT, 8'h00);
    rd8(8'h00, 8'h00);
    $display("t_reset done");
  endtask
  task t_sof;
    fork
      uef_host_model_i.sof(11'h7A3, 1'h1);
      begin
        repeat (2) @(posedge i_clock);
        #1 chk({7'h00, o_sof_irq}, 8'h01);
        @(posedge i_clock);
        #1 chk({7'h00, o_sof_irq}, 8'h00);
      end
    join
    rd8(UEF_ADDR_FRAME_LOW, 8'hA3);
    rd8(UEF_ADDR_FRAME_HIGH, 8'h27);
    wr8(UEF_ADDR_FRAME_LOW, 8'h11);
    rd8(UEF_ADDR_FRAME_LOW, 8'hA3);
    uef_host_model_i.sof(11'h0FF, 1'h0);
    rd8(UEF_ADDR_FRAME_LOW, 8'hA3);
    rd8(UEF_ADDR_FRAME_HIGH, 8'h17);
    $display("t_sof done");
  endtask
  task t_rx;
    uef_host_model_i.pkt(2'h0, 16, 8'h40);
    #1 chk({7'h00, o_rx_ready}, 8'h00);
    rd8(UEF_ADDR_BYTE_COUNT, 8'h10);
    for (int i = 0; i < 16; i++) rd8(UEF_ADDR_FIFO_DATA, 8'h40 + 8'(i));
    uef_host_model_i.pkt(2'h2, 3, 8'h70);
    i_endpoint_select <= 2'h2;
    rd8(UEF_ADDR_BYTE_COUNT, 8'h03);
    i_endpoint_select <= 2'h0;
    rd8(UEF_ADDR_BYTE_COUNT, 8'h10);
    $display("t_rx done");
  endtask
  task t_tx;
    i_endpoint_select <= 2'h2;
    i_tx_ep <= 2'h2;
    rd8(UEF_ADDR_FIFO_DATA, 8'h70);
    wr8(UEF_ADDR_FIFO_DATA, 8'hC5);
    uef_host_model_i.take(b);
    chk(b, 8'h71);
    uef_host_model_i.take(b);
    chk(b, 8'h72);
    uef_host_model_i.take(b);
    chk(b, 8'hC5);
    $display("t_tx done");
  endtask
  initial begin
    i_arst_n = 1'h0;
    i_clk_en = 1'h1;
    i_sfr_addr = 8'h00;
    i_sfr_wdata = 8'h00;
    i_sfr_wr = 1'h0;
    i_sfr_rd = 1'h0;
    i_endpoint_select = 2'h0;
    i_tx_ep = 2'h0;
    repeat (10) @(posedge i_clock);
    i_arst_n <= 1'h1;
    repeat (3) @(posedge i_clock);
    t_reset();
    t_sof();
    t_rx();
    t_tx();
    results();
  end
  // Whole run is about a hundred and ten cycles; this margin of 5000 cycles only catches a hang
  initial begin
    #500000;
    bad_count++;
    $display("[FAIL] %0t watchdog", $time);
    results();
  end
endmodule

// ---- uef_fifo.sv ----
/*
  Synchronous first-in first-out buffer with valid/ready on both sides.
  Assumes one clock; the enable freezes every flip-flop while low.
*/
`timescale 1ns/100ps
module uef_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty when the indices match
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]) && (wr_ptr_r[AW] != rd_ptr_r[AW]);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign push = i_enable & i_in_valid & ~full;
  assign pop = i_enable & i_out_ready & ~empty;
  assign o_out_data = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule

// ---- uef_host_model.sv ----
/* Host and serial engine stand-in for uef_regs.
   Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module uef_host_model (
  input wire logic i_clock,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  output logic o_sof_pid = 1'h0,
  output logic o_sof_done = 1'h0,
  output logic [10:0] o_sof_frame = 11'h000,
  output logic o_sof_ok = 1'h0,
  output logic [1:0] o_rx_ep = 2'h0,
  output logic o_rx_pid = 1'h0,
  output logic o_rx_valid = 1'h0,
  output logic [7:0] o_rx_byte = 8'h00,
  output logic o_rx_end = 1'h0,
  output logic o_tx_ready = 1'h0
);
  task automatic sof(input logic [10:0] f, input logic ok);
    @(posedge i_clock);
    o_sof_pid <= 1'h1;
    @(posedge i_clock);
    o_sof_pid <= 1'h0;
    o_sof_done <= 1'h1;
    o_sof_frame <= f;
    o_sof_ok <= ok;
    @(posedge i_clock);
    o_sof_done <= 1'h0;
    // Stale fields flip so a late sample shows up
    o_sof_frame <= ~f;
    o_sof_ok <= ~ok;
  endtask
  task automatic pkt(input logic [1:0] e, input int n, input logic [7:0] b0);
    @(posedge i_clock);
    o_rx_ep <= e;
    o_rx_pid <= 1'h1;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clock);
      o_rx_pid <= 1'h0;
      o_rx_valid <= 1'h1;
      o_rx_byte <= b0 + 8'(i);
      o_rx_end <= i == n - 1;
      @(negedge i_clock);
      while (!i_rx_ready) @(negedge i_clock);
    end
    @(posedge i_clock);
    o_rx_valid <= 1'h0;
    o_rx_end <= 1'h0;
    o_rx_byte <= ~o_rx_byte;
  endtask
  task automatic take(output logic [7:0] b);
    @(posedge i_clock);
    o_tx_ready <= 1'h1;
    @(negedge i_clock);
    while (!i_tx_valid) @(negedge i_clock);
    b = i_tx_byte;
    @(posedge i_clock);
    o_tx_ready <= 1'h0;
  endtask
endmodule

// ---- uef_pkg.sv ----
/*
  Shared constants of the endpoint FIFO, byte count and frame number register block.
  Assumes an 8-bit special-function-register bus with byte addresses.
*/
package uef_pkg;

  // Register addresses on the special-function-register bus
  localparam logic [7:0] UEF_ADDR_FRAME_LOW = 8'hBA;
  localparam logic [7:0] UEF_ADDR_FRAME_HIGH = 8'hBB;
  localparam logic [7:0] UEF_ADDR_FIFO_DATA = 8'hCF;
  localparam logic [7:0] UEF_ADDR_BYTE_COUNT = 8'hE2;

  // Field positions in the frame-number high register
  localparam int UEF_FRAME_HIGH_LSB = 0;
  localparam int UEF_FRAME_HIGH_MSB = 2;
  localparam int UEF_FRAME_HIGH_RSVD_BIT = 3;
  localparam int UEF_CHECK_BAD_BIT = 4;
  localparam int UEF_CHECK_GOOD_BIT = 5;

  // Field positions in the byte-count register
  localparam int UEF_BYTE_COUNT_MSB = 6;
  localparam int UEF_BYTE_COUNT_RSVD_BIT = 7;

  // Widths
  localparam int UEF_DATA_W = 8;
  localparam int UEF_FRAME_W = 11;
  localparam int UEF_COUNT_W = 7;
  localparam int UEF_EP_W = 2;

  // Sizes
  localparam int UEF_NUM_EP = 3;
  localparam int UEF_FIFO_DEPTH = 16;

  // Reset values
  localparam logic [7:0] UEF_RST_FRAME_LOW = 8'h00;
  localparam logic [2:0] UEF_RST_FRAME_HIGH = 3'h0;
  localparam logic [6:0] UEF_RST_BYTE_COUNT = 7'h00;
  localparam logic UEF_RST_CHECK_FLAG = 1'b0;
  localparam logic [7:0] UEF_READ_ZERO = 8'h00;

endpackage

// ---- uef_regs.sv ----
/*
  Endpoint FIFO access, received byte count and start-of-frame number registers
  of a full-speed USB function, seen from the microcontroller register bus.
  Assumes the serial engine on the same clock delivers packet events as one-cycle
  pulses, and that the endpoint select comes from the endpoint select register.
*/
`timescale 1ns/100ps

// Behaviour
// (R1) Register data write pushes, read pops, one byte of the selected endpoint FIFO.
// (R2) Byte count shows bytes received after Data PID of last packet, selected endpoint.
// (R3) Byte-count bit 7 and frame-high bit 3 always read zero.
// (R4) Low frame register shows frame number bits 7..0, read-only, resets zero.
// (R5) High frame register bits 2..0 show frame bits 10..8, resets zero.
// (R6) Good-check flag set after start-of-frame with intact frame number.
// (R7) Bad-check flag set after start-of-frame with corrupted frame number.
// (R8) Start-of-frame interrupt pulses right after the start-of-frame PID.
// (R9) Byte count resets to zero; FIFO data has no defined reset value.
// (R10) Frame number registers update only on intact start-of-frame packets.
// (R11) Exactly one check flag set per start-of-frame; the other cleared.
module uef_regs #(
  parameter int NUM_EP = uef_pkg::UEF_NUM_EP,
  parameter int FIFO_DEPTH = uef_pkg::UEF_FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // Register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [uef_pkg::UEF_DATA_W-1:0] i_sfr_wdata,
  output logic [uef_pkg::UEF_DATA_W-1:0] o_sfr_rdata,
  input wire logic [uef_pkg::UEF_EP_W-1:0] i_endpoint_select,
  // Start-of-frame events from the serial engine
  input wire logic i_sof_pid,
  input wire logic i_sof_done,
  input wire logic [uef_pkg::UEF_FRAME_W-1:0] i_sof_frame,
  input wire logic i_sof_crc_ok,
  output logic o_sof_irq,
  // Received data packets from the serial engine
  input wire logic [uef_pkg::UEF_EP_W-1:0] i_rx_ep,
  input wire logic i_rx_data_pid,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [uef_pkg::UEF_DATA_W-1:0] i_rx_byte,
  input wire logic i_rx_end,
  // Bytes to transmit toward the serial engine
  input wire logic [uef_pkg::UEF_EP_W-1:0] i_tx_ep,
  output logic o_tx_valid,
  input wire logic i_tx_ready,
  output logic [uef_pkg::UEF_DATA_W-1:0] o_tx_byte
);
  import uef_pkg::*;

  localparam logic [UEF_COUNT_W-1:0] COUNT_MAX = '1;

  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;

  logic [UEF_FRAME_W-1:0] frame_r;
  logic check_good_r;
  logic check_bad_r;
  logic sof_irq_r;
  logic [UEF_DATA_W-1:0] rdata_r;
  logic [UEF_DATA_W-1:0] rdata_nxt;

  logic sel_ok;
  logic rx_ep_ok;
  logic tx_ep_ok;
  logic cpu_fifo_wr;
  logic cpu_fifo_rd;

  logic [NUM_EP-1:0] in_valid;
  logic [NUM_EP-1:0] in_ready;
  logic [NUM_EP-1:0] out_valid;
  logic [NUM_EP-1:0] out_ready;
  logic [UEF_DATA_W-1:0] in_data [NUM_EP];
  logic [UEF_DATA_W-1:0] out_data [NUM_EP];
  logic [UEF_COUNT_W-1:0] run_count_r [NUM_EP];
  logic [UEF_COUNT_W-1:0] byte_count_r [NUM_EP];
  logic [NUM_EP-1:0] rx_take;

  // Reset is released through two flops so the release is clean to this clock
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Internal reset lags the pin by two edges; the first access must wait for it
  assign rst_n = rst_sync_r;

  // Endpoint numbers beyond the implemented set reach no FIFO
  assign sel_ok = (32'(i_endpoint_select) < NUM_EP);
  assign rx_ep_ok = (32'(i_rx_ep) < NUM_EP);
  assign tx_ep_ok = (32'(i_tx_ep) < NUM_EP);

  // (R3) Reserved bits have no storage; writes to read-only addresses are ignored
  // (R1) Register access decode
  assign cpu_fifo_wr = i_clk_en & i_sfr_wr & (i_sfr_addr == UEF_ADDR_FIFO_DATA) & sel_ok;
  assign cpu_fifo_rd = i_clk_en & i_sfr_rd & (i_sfr_addr == UEF_ADDR_FIFO_DATA) & sel_ok;

  genvar ep;
  generate
    for (ep = 0; ep < NUM_EP; ep++) begin : g_ep
      logic cpu_wr_here;
      logic cpu_rd_here;
      logic rx_here;
      logic tx_here;

      assign cpu_wr_here = cpu_fifo_wr && (32'(i_endpoint_select) == ep);
      assign cpu_rd_here = cpu_fifo_rd && (32'(i_endpoint_select) == ep);
      assign rx_here = rx_ep_ok && (32'(i_rx_ep) == ep);
      assign tx_here = tx_ep_ok && (32'(i_tx_ep) == ep);

      // (R1) CPU write pushes; it wins the port, so the link is stalled meanwhile
      assign in_valid[ep] = cpu_wr_here | (rx_here & i_rx_valid);
      assign in_data[ep] = cpu_wr_here ? i_sfr_wdata : i_rx_byte;
      assign rx_take[ep] = rx_here & i_rx_valid & ~cpu_wr_here & in_ready[ep] & i_clk_en;

      // (R1) CPU read pops; the transmit drain waits a cycle when they collide
      assign out_ready[ep] = cpu_rd_here | (tx_here & i_tx_ready);

      uef_fifo #(
        .WIDTH(UEF_DATA_W),
        .DEPTH(FIFO_DEPTH)
      ) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(rst_n),
        .i_enable(i_clk_en),
        .i_in_valid(in_valid[ep]),
        .o_in_ready(in_ready[ep]),
        .i_in_data(in_data[ep]),
        .o_out_valid(out_valid[ep]),
        .i_out_ready(out_ready[ep]),
        .o_out_data(out_data[ep])
      );

      // (R2) Count bytes after the Data PID, latch at packet end
      // Saturates instead of wrapping, so an oversize packet reads full scale
      always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          run_count_r[ep] <= UEF_RST_BYTE_COUNT;
        end else if (i_clk_en && rx_here) begin
          if (i_rx_data_pid) begin
            run_count_r[ep] <= UEF_RST_BYTE_COUNT;
          end else if (rx_take[ep] && run_count_r[ep] != COUNT_MAX) begin
            run_count_r[ep] <= run_count_r[ep] + 1'b1;
          end
        end
      end

      // (R9) Byte count resets to zero
      // FIFO memory has no reset, so its data is undefined until written
      always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
          byte_count_r[ep] <= UEF_RST_BYTE_COUNT;
        end else if (i_clk_en && rx_here && i_rx_end) begin
          // A byte taken in the end cycle still belongs to the packet
          if (rx_take[ep] && run_count_r[ep] != COUNT_MAX) begin
            byte_count_r[ep] <= run_count_r[ep] + 1'b1;
          end else begin
            byte_count_r[ep] <= run_count_r[ep];
          end
        end
      end
    end
  endgenerate

  // The link sees a stall whenever the CPU owns the target FIFO port
  logic rx_stall;
  logic tx_stall;

  assign rx_stall = cpu_fifo_wr && (i_endpoint_select == i_rx_ep);
  assign tx_stall = cpu_fifo_rd && (i_endpoint_select == i_tx_ep);

  always_comb begin
    o_rx_ready = 1'b0;
    if (rx_ep_ok) begin
      o_rx_ready = in_ready[i_rx_ep] & ~rx_stall;
    end
  end

  always_comb begin
    o_tx_valid = 1'b0;
    o_tx_byte = UEF_READ_ZERO;
    if (tx_ep_ok) begin
      o_tx_valid = out_valid[i_tx_ep] & ~tx_stall;
      o_tx_byte = out_data[i_tx_ep];
    end
  end

  // (R8) Interrupt pulse follows the PID, before frame number and check exist
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sof_irq_r <= 1'b0;
    end else if (i_clk_en) begin
      sof_irq_r <= i_sof_pid;
    end
  end

  assign o_sof_irq = sof_irq_r;

  // (R10) Frame number kept on a corrupted packet
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_r <= {UEF_RST_FRAME_HIGH, UEF_RST_FRAME_LOW};
    end else if (i_clk_en && i_sof_done && i_sof_crc_ok) begin
      frame_r <= i_sof_frame;
    end
  end

  // (R6) (R7) (R11) One flag per reception, the other cleared
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      check_good_r <= UEF_RST_CHECK_FLAG;
      check_bad_r <= UEF_RST_CHECK_FLAG;
    end else if (i_clk_en && i_sof_done) begin
      check_good_r <= i_sof_crc_ok;
      check_bad_r <= ~i_sof_crc_ok;
    end
  end

  // Register images, built once so the read mux only selects
  logic [UEF_DATA_W-1:0] frame_low_view;
  logic [UEF_DATA_W-1:0] frame_high_view;
  logic [UEF_DATA_W-1:0] count_view;
  logic [UEF_DATA_W-1:0] fifo_view;

  // (R4) Low frame byte
  assign frame_low_view = frame_r[UEF_DATA_W-1:0];

  // (R5) (R3) High frame bits, check flags, reserved zero
  always_comb begin
    frame_high_view = UEF_READ_ZERO;
    frame_high_view[UEF_FRAME_HIGH_MSB:UEF_FRAME_HIGH_LSB] = frame_r[UEF_FRAME_W-1:UEF_DATA_W];
    frame_high_view[UEF_FRAME_HIGH_RSVD_BIT] = 1'b0;
    frame_high_view[UEF_CHECK_BAD_BIT] = check_bad_r;
    frame_high_view[UEF_CHECK_GOOD_BIT] = check_good_r;
  end

  // (R2) (R3) Count in low bits, reserved top bit zero
  always_comb begin
    count_view = UEF_READ_ZERO;
    if (sel_ok) begin
      count_view[UEF_BYTE_COUNT_MSB:0] = byte_count_r[i_endpoint_select];
    end
    count_view[UEF_BYTE_COUNT_RSVD_BIT] = 1'b0;
  end

  // (R1) Head byte of the selected FIFO, popped in the same cycle
  // An empty FIFO answers stale memory and its pointer stays put
  always_comb begin
    fifo_view = UEF_READ_ZERO;
    if (sel_ok) begin
      fifo_view = out_data[i_endpoint_select];
    end
  end

  // Read data mux; unmapped addresses answer zero
  always_comb begin
    rdata_nxt = UEF_READ_ZERO;
    case (i_sfr_addr)
      UEF_ADDR_FRAME_LOW: begin
        rdata_nxt = frame_low_view;
      end
      UEF_ADDR_FRAME_HIGH: begin
        rdata_nxt = frame_high_view;
      end
      UEF_ADDR_FIFO_DATA: begin
        rdata_nxt = fifo_view;
      end
      UEF_ADDR_BYTE_COUNT: begin
        rdata_nxt = count_view;
      end
      default: begin
        rdata_nxt = UEF_READ_ZERO;
      end
    endcase
  end

  // Read data is held until the next read so the CPU may sample it late
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= UEF_READ_ZERO;
    end else if (i_clk_en && i_sfr_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_sfr_rdata = rdata_r;

endmodule

// ---- uef_regs_properties.sv ----
/* Port checker for uef_regs.
   Assumes one clock and a bench that keeps clk_en high. */
`timescale 1ns/100ps
module uef_regs_properties
  import uef_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic [1:0] i_endpoint_select,
  input wire logic i_sof_pid,
  input wire logic o_sof_irq,
  input wire logic [1:0] i_rx_ep,
  input wire logic o_rx_ready,
  input wire logic [1:0] i_tx_ep,
  input wire logic o_tx_valid
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic rd;
  logic fw;
  logic hi;
  assign rd = i_sfr_rd & i_clk_en;
  assign fw = i_sfr_addr == UEF_ADDR_FIFO_DATA;
  assign hi = rd && i_sfr_addr == UEF_ADDR_FRAME_HIGH;
  a_irq_follows: assert property (
    i_sof_pid && i_clk_en |=> o_sof_irq) else $error("no irq");
  a_irq_cause: assert property (
    o_sof_irq |-> $past(i_sof_pid)) else $error("stray irq");
  a_rx_cpu_first: assert property (
    i_clk_en && i_sfr_wr && fw && i_endpoint_select == i_rx_ep |-> !o_rx_ready)
    else $error("rx clash");
  a_tx_cpu_first: assert property (
    i_clk_en && i_sfr_rd && fw && i_endpoint_select == i_tx_ep |-> !o_tx_valid)
    else $error("tx clash");
  a_rdata_holds: assert property (
    !rd |=> $stable(o_sfr_rdata)) else $error("rdata moved");
  a_high_rsvd: assert property (
    hi |=> o_sfr_rdata[7:6] == 2'h0 && !o_sfr_rdata[3]) else $error("high rsvd");
  a_count_rsvd: assert property (
    rd && i_sfr_addr == UEF_ADDR_BYTE_COUNT |=> !o_sfr_rdata[7]) else $error("count rsvd");
  a_flags_one: assert property (
    hi |=> !(o_sfr_rdata[5] && o_sfr_rdata[4])) else $error("both flags");
endmodule
bind uef_regs uef_regs_properties uef_regs_properties_i (.*);
